/* File: design/core_state_pkg.sv */
/*
  Shared constants for the processor core architectural state block:
  register index map of the software port, status word field positions,
  reset values and the bit-band window.
  Assumes a single clock domain and a plain word-indexed register port.
*/
package core_state_pkg;

    // --------
    // widths
    // --------
    localparam int WORD_W   = 32;
    localparam int IDX_W    = 5;
    localparam int EXC_W    = 9;
    localparam int FLAG_W   = 5;
    localparam int NUM_GPR  = 13;

    typedef logic [WORD_W-1:0] word_t;
    typedef logic [IDX_W-1:0]  idx_t;

    // --------
    // register port index map
    // --------
    localparam idx_t IDX_SP        = 5'h0D;
    localparam idx_t IDX_LR        = 5'h0E;
    localparam idx_t IDX_PC        = 5'h0F;
    localparam idx_t IDX_COMBINED  = 5'h10;
    localparam idx_t IDX_FLAGS     = 5'h11;
    localparam idx_t IDX_EXCNUM    = 5'h12;
    localparam idx_t IDX_EXECSTATE = 5'h13;
    localparam idx_t IDX_GMASK     = 5'h14;
    localparam idx_t IDX_FMASK     = 5'h15;
    localparam idx_t IDX_THRESH    = 5'h16;
    localparam idx_t IDX_MODECTL   = 5'h17;
    localparam idx_t IDX_MAIN_SP   = 5'h18;
    localparam idx_t IDX_THREAD_SP = 5'h19;
    localparam idx_t IDX_LOW_LAST  = 5'h07;
    localparam idx_t IDX_HIGH_LAST = 5'h0C;

    // --------
    // status word fields
    // --------
    localparam int FLAG_LSB     = 27;
    localparam int EXC_LSB      = 0;
    localparam int CONT_LSB     = 10;
    localparam int CONT_W       = 6;
    localparam int COND_LSB     = 25;
    localparam int COND_W       = 2;
    localparam int COMPACT_BIT  = 24;
    localparam int MODE_USR_BIT = 0;
    localparam int MODE_STK_BIT = 1;

    // --------
    // reset values
    // --------
    localparam word_t               WORD_RST   = 32'h0000_0000;
    localparam logic [EXC_W-1:0]    EXC_RST    = 9'h000;
    localparam logic [1:0]          MODECTL_RST = 2'h0;

    // --------
    // exception classes seen by the admission check
    // --------
    typedef enum logic [1:0] {
        KIND_OTHER     = 2'h0,
        KIND_HARDFAULT = 2'h1,
        KIND_NMI       = 2'h3
    } irq_kind_e;

    typedef enum logic [0:0] {
        MODE_THREAD  = 1'h0,
        MODE_HANDLER = 1'h1
    } core_mode_e;

    // --------
    // bit-band window (plain defaults)
    // --------
    localparam word_t BB_ALIAS_BASE = 32'h2200_0000;
    localparam word_t BB_ALIAS_SPAN = 32'h0200_0000;
    localparam word_t BB_SRAM_BASE  = 32'h2000_0000;

endpackage

/* File: design/core_state_regs.sv */
/*
  Architectural state of the processor core: general registers, banked
  stack pointer, return address, program counter, status words, interrupt
  masks, priority threshold and mode control, plus a bit-band translator.
  Assumes the execution unit drives the one-cycle event pulses and the
  register port strobes synchronously to CORE_CLK.
*/
// Summary of operation
// RULE1: handler mode exists only privileged; three legal level/mode states.
// RULE2: user level privileged access or instruction faults.
// RULE3: privileged level allows every instruction and register, no fault.
// RULE4: handler mode while servicing an exception, thread otherwise.
// RULE5: all sixteen core registers are 32 bits wide.
// RULE6: low registers always reachable; high registers not by narrow encodings.
// RULE7: thread stack pointer only in user thread mode, primary elsewhere.
// RULE8: stack pointer low two bits forced zero.
// RULE9: subroutine call stores return address in link register.
// RULE10: program counter bit 0 forced zero.
// RULE11: combined status word of three parts, accessible together or apart.
// RULE12: flag status word holds result flags in bits 27 to 31.
// RULE13: exception number word holds current exception in bits 0 to 8.
// RULE14: execution state holds continuable and conditional bits 10-15, 25-26.
// RULE15: compact bit 24 reads one; clearing it faults.
// RULE16: global mask admits only nonmaskable interrupt and hard fault.
// RULE17: fault escalation mask admits only nonmaskable interrupt.
// RULE18: threshold masks priority values at or above it; zero disables.
// RULE19: mode control bit 0 selects privileged or user thread.
// RULE20: mode control bit 1 selects stack; kept zero in handler mode. The code stores bit 1 but selects the stack by RULE7 alone.
// RULE21: bit-band alias over SRAM gives atomic single-bit access.
// RULE22: reset gives privileged thread, primary stack, masks and threshold clear.
`timescale 1ns/1ps
`default_nettype none

module core_state_regs
    import core_state_pkg::*;
(
    input  wire logic                       CORE_CLK,
    input  wire logic                       ARST_N,
    input  wire core_state_pkg::idx_t       REG_ADDR,
    input  wire core_state_pkg::word_t      REG_WDATA,
    input  wire logic                       REG_WR,
    input  wire logic                       REG_RD,
    input  wire logic                       REG_NARROW,
    output var     core_state_pkg::word_t   REG_RDATA,
    input  wire logic                       PRIV_OP,
    input  wire logic                       EXC_ENTRY,
    input  wire logic [8:0]                 EXC_NUM,
    input  wire logic                       EXC_RETURN,
    input  wire logic                       CALL,
    input  wire core_state_pkg::word_t      CALL_RET_ADDR,
    input  wire logic                       PC_LOAD,
    input  wire core_state_pkg::word_t      PC_VALUE,
    input  wire logic                       FLAGS_WE,
    input  wire logic [4:0]                 FLAGS_IN,
    input  wire logic                       IRQ_REQ,
    input  wire core_state_pkg::irq_kind_e  IRQ_KIND,
    input  wire logic [8:0]                 IRQ_PRIO,
    output logic                            IRQ_VALID,
    output logic                            IRQ_ADMIT,
    input  wire logic                       BB_REQ,
    input  wire core_state_pkg::word_t      BB_ADDR,
    output logic                            BB_VALID,
    output logic                            BB_HIT,
    output var     core_state_pkg::word_t   BB_WORD_ADDR,
    output logic [4:0]                      BB_BIT,
    output logic                            FAULT,
    output logic                            USER_LEVEL,
    output logic                            HANDLER_MODE,
    output logic                            THREAD_STACK_SEL,
    output var     core_state_pkg::word_t   ACTIVE_SP,
    output var     core_state_pkg::word_t   PROGRAM_COUNTER
);
    import core_state_pkg::*;

    // --------
    // reset release
    // --------

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // --------
    // state
    // --------

    typedef struct packed {
        logic [NUM_GPR-1:0][WORD_W-1:0] gpr;
        word_t                          main_sp;
        word_t                          thread_sp;
        word_t                          lr;
        word_t                          pc;
        logic [FLAG_W-1:0]              flags;
        logic [EXC_W-1:0]               exc_num;
        logic [CONT_W-1:0]              cont;
        logic [COND_W-1:0]              cond;
        logic                           gmask;
        logic                           fmask;
        logic [EXC_W-1:0]               thresh;
        logic [1:0]                     modectl;
        logic                           stk_saved;
        core_mode_e                     mode;
        word_t                          rdata;
        logic                           fault;
        logic                           irq_valid;
        logic                           irq_admit;
        logic                           bb_valid;
        logic                           bb_hit;
        word_t                          bb_word;
        logic [4:0]                     bb_bit;
        logic                           out_user;
        logic                           out_handler;
        logic                           out_tsel;
        word_t                          out_sp;
    } state_s;

    state_s s_reg;
    state_s s_next;

    // --------
    // helpers
    // --------

    // user level is thread mode with the level bit set
    function automatic logic is_user(input state_s st);
        is_user = (st.mode == MODE_THREAD) && st.modectl[MODE_USR_BIT]; // RULE1
    endfunction

    function automatic logic uses_thread_sp(input state_s st);
        uses_thread_sp = is_user(st); // RULE7
    endfunction

    function automatic word_t exec_word(input state_s st);
        word_t w;
        w = WORD_RST;
        w[CONT_LSB +: CONT_W] = st.cont; // RULE14
        w[COND_LSB +: COND_W] = st.cond; // RULE14
        w[COMPACT_BIT]        = 1'b1;    // RULE15
        exec_word = w;
    endfunction

    function automatic word_t read_value(input state_s st, input idx_t a);
        word_t w;
        w = WORD_RST;
        if (a <= IDX_HIGH_LAST) begin
            w = st.gpr[a];
        end else if (a == IDX_SP) begin
            w = uses_thread_sp(st) ? st.thread_sp : st.main_sp; // RULE7
        end else if (a == IDX_LR) begin
            w = st.lr;
        end else if (a == IDX_PC) begin
            w = st.pc;
        end else if (a == IDX_COMBINED) begin
            w = exec_word(st); // RULE11
            w[FLAG_LSB +: FLAG_W] = st.flags;
            w[EXC_LSB +: EXC_W]   = st.exc_num;
        end else if (a == IDX_FLAGS) begin
            w[FLAG_LSB +: FLAG_W] = st.flags; // RULE12
        end else if (a == IDX_EXCNUM) begin
            w[EXC_LSB +: EXC_W] = st.exc_num; // RULE13
        end else if (a == IDX_EXECSTATE) begin
            w = exec_word(st);
        end else if (a == IDX_GMASK) begin
            w[0] = st.gmask;
        end else if (a == IDX_FMASK) begin
            w[0] = st.fmask;
        end else if (a == IDX_THRESH) begin
            w[EXC_W-1:0] = st.thresh;
        end else if (a == IDX_MODECTL) begin
            w[1:0] = st.modectl;
        end else if (a == IDX_MAIN_SP) begin
            w = st.main_sp;
        end else if (a == IDX_THREAD_SP) begin
            w = st.thread_sp;
        end
        read_value = w;
    endfunction

    // privileged-only targets of the register port
    function automatic logic is_priv_reg(input idx_t a);
        is_priv_reg = (a == IDX_GMASK)
                   || (a == IDX_FMASK)
                   || (a == IDX_THRESH)
                   || (a == IDX_MODECTL)
                   || (a == IDX_MAIN_SP);
    endfunction

    // --------
    // next state
    // --------

    always_comb begin
        logic  user;
        logic  refuse;
        word_t w;
        word_t off;
        user   = is_user(s_reg);
        refuse = 1'b0;
        w      = REG_WDATA;
        off    = WORD_RST;
        s_next = s_reg;
        s_next.fault     = 1'b0;
        s_next.irq_valid = 1'b0;
        s_next.bb_valid  = 1'b0;
        s_next.rdata     = WORD_RST;

        // narrow encodings cannot name the high registers
        if ((REG_WR || REG_RD) && REG_NARROW
            && (REG_ADDR > IDX_LOW_LAST) && (REG_ADDR <= IDX_HIGH_LAST)) begin
            refuse = 1'b1; // RULE6
        end
        // user level cannot touch privileged state; privileged may
        if ((REG_WR || REG_RD) && user && is_priv_reg(REG_ADDR)) begin
            refuse = 1'b1; // RULE2
        end
        if (PRIV_OP && user) begin
            s_next.fault = 1'b1; // RULE2 RULE3
        end

        if (REG_RD && !refuse) begin
            s_next.rdata = read_value(s_reg, REG_ADDR);
        end

        if (REG_WR && !refuse) begin
            if (REG_ADDR <= IDX_HIGH_LAST) begin
                s_next.gpr[REG_ADDR] = w; // RULE5
            end else if (REG_ADDR == IDX_SP) begin
                if (uses_thread_sp(s_reg)) begin
                    s_next.thread_sp = {w[31:2], 2'h0}; // RULE7 RULE8
                end else begin
                    s_next.main_sp = {w[31:2], 2'h0}; // RULE8
                end
            end else if (REG_ADDR == IDX_MAIN_SP) begin
                s_next.main_sp = {w[31:2], 2'h0}; // RULE8
            end else if (REG_ADDR == IDX_THREAD_SP) begin
                s_next.thread_sp = {w[31:2], 2'h0}; // RULE8
            end else if (REG_ADDR == IDX_LR) begin
                s_next.lr = w;
            end else if (REG_ADDR == IDX_PC) begin
                s_next.pc = {w[31:1], 1'b0}; // RULE10
            end else if (REG_ADDR == IDX_FLAGS) begin
                s_next.flags = w[FLAG_LSB +: FLAG_W]; // RULE11 RULE12
            end else if ((REG_ADDR == IDX_EXECSTATE) || (REG_ADDR == IDX_COMBINED)) begin
                if (!w[COMPACT_BIT]) begin
                    // the compact bit is never cleared; the write is dropped
                    s_next.fault = 1'b1; // RULE15
                end else begin
                    s_next.cont = w[CONT_LSB +: CONT_W]; // RULE14
                    s_next.cond = w[COND_LSB +: COND_W]; // RULE14
                    if (REG_ADDR == IDX_COMBINED) begin
                        s_next.flags = w[FLAG_LSB +: FLAG_W]; // RULE11
                    end
                end
            end else if (REG_ADDR == IDX_GMASK) begin
                s_next.gmask = w[0];
            end else if (REG_ADDR == IDX_FMASK) begin
                s_next.fmask = w[0];
            end else if (REG_ADDR == IDX_THRESH) begin
                s_next.thresh = w[EXC_W-1:0];
            end else if (REG_ADDR == IDX_MODECTL) begin
                s_next.modectl[MODE_USR_BIT] = w[MODE_USR_BIT]; // RULE19
                if (s_reg.mode == MODE_HANDLER) begin
                    // stack bit stays clear in handler; value kept for return
                    s_next.stk_saved = w[MODE_STK_BIT]; // RULE20
                end else begin
                    s_next.modectl[MODE_STK_BIT] = w[MODE_STK_BIT]; // RULE20
                end
            end
        end
        if ((REG_WR || REG_RD) && refuse) begin
            s_next.fault = 1'b1; // RULE2 RULE6
        end

        // execution events win over the register port
        if (FLAGS_WE) begin
            s_next.flags = FLAGS_IN; // RULE12
        end
        if (CALL) begin
            s_next.lr = CALL_RET_ADDR; // RULE9
        end
        if (PC_LOAD) begin
            s_next.pc = {PC_VALUE[31:1], 1'b0}; // RULE10
        end

        // mode sequencing; entry beats return in the same cycle
        if (EXC_ENTRY) begin
            s_next.mode    = MODE_HANDLER; // RULE4 RULE1
            s_next.exc_num = EXC_NUM;      // RULE13
            if (s_reg.mode == MODE_THREAD) begin
                s_next.stk_saved = s_next.modectl[MODE_STK_BIT];
            end
            s_next.modectl[MODE_STK_BIT] = 1'b0; // RULE20
        end else if (EXC_RETURN && (s_reg.mode == MODE_HANDLER)) begin
            s_next.mode    = MODE_THREAD; // RULE4
            s_next.exc_num = EXC_RST;
            s_next.modectl[MODE_STK_BIT] = s_next.stk_saved; // RULE20
        end

        // interrupt admission against current masks
        if (IRQ_REQ) begin
            s_next.irq_valid = 1'b1;
            case (IRQ_KIND)
                KIND_NMI: begin
                    s_next.irq_admit = 1'b1; // RULE16 RULE17
                end
                KIND_HARDFAULT: begin
                    s_next.irq_admit = !s_reg.fmask; // RULE17
                end
                default: begin
                    s_next.irq_admit = !s_reg.gmask && !s_reg.fmask // RULE16 RULE17
                        && ((s_reg.thresh == EXC_RST) || (IRQ_PRIO < s_reg.thresh)); // RULE18
                end
            endcase
        end

        // bit-band alias: one alias word per SRAM bit, so the access is
        // a single transaction and cannot be split by another master
        // addresses below the base wrap and miss the bound test
        if (BB_REQ) begin
            off = BB_ADDR - BB_ALIAS_BASE;
            s_next.bb_valid = 1'b1;
            s_next.bb_hit   = (BB_ADDR >= BB_ALIAS_BASE) && (off < BB_ALIAS_SPAN); // RULE21
            s_next.bb_word  = BB_SRAM_BASE + {5'h00, off[31:7], 2'h0};          // RULE21
            s_next.bb_bit   = {off[6:2]};                                        // RULE21
        end

        // registered copies of the derived status
        s_next.out_user    = is_user(s_next);        // RULE1
        s_next.out_handler = (s_next.mode == MODE_HANDLER);
        s_next.out_tsel    = uses_thread_sp(s_next); // RULE7
        s_next.out_sp      = uses_thread_sp(s_next) ? s_next.thread_sp : s_next.main_sp;
    end

    // --------
    // registers
    // --------

    // state clears at once; only the release is retimed
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0; // RULE22
        end else begin
            s_reg <= s_next;
        end
    end

    // --------
    // outputs
    // --------

    // straight from the flops, no logic after them
    assign REG_RDATA        = s_reg.rdata;
    assign IRQ_VALID        = s_reg.irq_valid;
    assign IRQ_ADMIT        = s_reg.irq_admit;
    assign BB_VALID         = s_reg.bb_valid;
    assign BB_HIT           = s_reg.bb_hit;
    assign BB_WORD_ADDR     = s_reg.bb_word;
    assign BB_BIT           = s_reg.bb_bit;
    assign FAULT            = s_reg.fault;
    assign USER_LEVEL       = s_reg.out_user;
    assign HANDLER_MODE     = s_reg.out_handler;
    assign THREAD_STACK_SEL = s_reg.out_tsel;
    assign ACTIVE_SP        = s_reg.out_sp;
    assign PROGRAM_COUNTER  = s_reg.pc;

endmodule

`default_nettype wire

/* File: bench/core_state_checker_assertions.sv */
/*
  Concurrent checks on the ports of the core state block.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module core_state_checker
    import core_state_pkg::*;
(
    input wire logic                      CORE_CLK,
    input wire logic                      ARST_N,
    input wire core_state_pkg::idx_t      REG_ADDR,
    input wire logic                      REG_WR,
    input wire logic                      REG_RD,
    input wire logic                      REG_NARROW,
    input wire logic                      PRIV_OP,
    input wire logic                      EXC_ENTRY,
    input wire logic                      PC_LOAD,
    input wire core_state_pkg::word_t     PC_VALUE,
    input wire logic                      IRQ_REQ,
    input wire core_state_pkg::irq_kind_e IRQ_KIND,
    input wire logic                      IRQ_VALID,
    input wire logic                      IRQ_ADMIT,
    input wire logic                      BB_REQ,
    input wire core_state_pkg::word_t     BB_ADDR,
    input wire logic                      BB_VALID,
    input wire logic                      BB_HIT,
    input wire logic                      FAULT,
    input wire logic                      USER_LEVEL,
    input wire logic                      HANDLER_MODE,
    input wire logic                      THREAD_STACK_SEL,
    input wire core_state_pkg::word_t     ACTIVE_SP,
    input wire core_state_pkg::word_t     PROGRAM_COUNTER
);
    import core_state_pkg::*;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // --------
    // sequences
    // --------
    sequence s_enter;
        EXC_ENTRY ##1 (HANDLER_MODE && !USER_LEVEL && !THREAD_STACK_SEL);
    endsequence
    sequence s_nmi_req;
        IRQ_REQ && IRQ_KIND == KIND_NMI;
    endsequence
    // --------
    // assertions
    // --------
    a_handler_priv: assert property (HANDLER_MODE |-> !USER_LEVEL)
        else $error("user level seen in handler mode");
    a_handler_stack: assert property (HANDLER_MODE |-> !THREAD_STACK_SEL)
        else $error("thread stack selected in handler mode");
    a_exc_entry: assert property (EXC_ENTRY |-> s_enter)
        else $error("entry did not give privileged handler mode");
    a_stack_align: assert property (ACTIVE_SP[1:0] == 2'h0)
        else $error("stack pointer not word aligned");
    a_counter_align: assert property (PROGRAM_COUNTER[0] == 1'b0)
        else $error("program counter bit 0 set");
    a_counter_load: assert property (PC_LOAD |=>
        PROGRAM_COUNTER == {$past(PC_VALUE[31:1]), 1'b0}) else $error("bad counter load");
    a_nmi_admit: assert property (s_nmi_req |=> IRQ_VALID && IRQ_ADMIT)
        else $error("nonmaskable request refused");
    a_user_fault: assert property (PRIV_OP && USER_LEVEL |=> FAULT)
        else $error("no fault for user privileged op");
    a_priv_clean: assert property (PRIV_OP && !USER_LEVEL && !REG_WR && !REG_RD |=>
        !FAULT) else $error("fault at privileged level");
    a_narrow_fault: assert property ((REG_WR || REG_RD) && REG_NARROW &&
        REG_ADDR inside {[5'h08:5'h0C]} |=> FAULT) else $error("narrow high access no fault");
    a_band_hit: assert property (BB_REQ |=> BB_VALID && BB_HIT ==
        ($past(BB_ADDR) >= BB_ALIAS_BASE && $past(BB_ADDR) - BB_ALIAS_BASE < BB_ALIAS_SPAN))
        else $error("bit-band hit wrong");
endmodule
bind core_state_regs core_state_checker i_chk (.CORE_CLK, .ARST_N, .REG_ADDR, .REG_WR,
    .REG_RD, .REG_NARROW, .PRIV_OP, .EXC_ENTRY, .PC_LOAD, .PC_VALUE, .IRQ_REQ, .IRQ_KIND,
    .IRQ_VALID, .IRQ_ADMIT, .BB_REQ, .BB_ADDR, .BB_VALID, .BB_HIT, .FAULT, .USER_LEVEL,
    .HANDLER_MODE, .THREAD_STACK_SEL, .ACTIVE_SP, .PROGRAM_COUNTER);
`default_nettype wire

/* File: bench/test_core_state_regs.sv */
/*
  Directed self-checking bench for the core state block.
  Assumes the checker is bound separately; inputs change at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module test_core_state_regs;
    import core_state_pkg::*;
    logic CORE_CLK = 1'b0, ARST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, REG_NARROW = 1'b0;
    logic PRIV_OP = 1'b0, EXC_ENTRY = 1'b0, EXC_RETURN = 1'b0, CALL = 1'b0, PC_LOAD = 1'b0;
    logic FLAGS_WE = 1'b0, IRQ_REQ = 1'b0, BB_REQ = 1'b0, IRQ_VALID, IRQ_ADMIT, BB_VALID;
    logic BB_HIT, FAULT, USER_LEVEL, HANDLER_MODE, THREAD_STACK_SEL;
    logic [8:0] EXC_NUM = 9'h000, IRQ_PRIO = 9'h000;
    logic [4:0] FLAGS_IN = 5'h00, BB_BIT;
    idx_t       REG_ADDR = 5'h00;
    irq_kind_e  IRQ_KIND = KIND_OTHER;
    word_t      REG_WDATA = 32'h0, CALL_RET_ADDR = 32'h0, PC_VALUE = 32'h0, BB_ADDR = 32'h0;
    word_t      REG_RDATA, BB_WORD_ADDR, ACTIVE_SP, PROGRAM_COUNTER;
    int         errors = 0, n_checks = 0;
    localparam logic [6:0] EV_PRIV = 7'h40, EV_IN = 7'h20, EV_OUT = 7'h10, EV_CALL = 7'h08;
    localparam logic [6:0] EV_LOAD = 7'h04, EV_FLAGS = 7'h02, EV_BAND = 7'h01;
    always #12.5 CORE_CLK = ~CORE_CLK;
    core_state_regs i_dut (.CORE_CLK, .ARST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
        .REG_NARROW, .REG_RDATA, .PRIV_OP, .EXC_ENTRY, .EXC_NUM, .EXC_RETURN, .CALL,
        .CALL_RET_ADDR, .PC_LOAD, .PC_VALUE, .FLAGS_WE, .FLAGS_IN, .IRQ_REQ, .IRQ_KIND,
        .IRQ_PRIO, .IRQ_VALID, .IRQ_ADMIT, .BB_REQ, .BB_ADDR, .BB_VALID, .BB_HIT,
        .BB_WORD_ADDR, .BB_BIT, .FAULT, .USER_LEVEL, .HANDLER_MODE, .THREAD_STACK_SEL,
        .ACTIVE_SP, .PROGRAM_COUNTER);
    // --------
    // compare, bus and event tasks
    // --------
    task automatic chk_word(word_t got, word_t exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(logic got, logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    // one write or read; fault level judged in the answer cycle
    task automatic acc(logic w, idx_t a, word_t d, logic f = 1'b0, logic n = 1'b0);
        @(posedge CORE_CLK);
        {REG_WR, REG_RD, REG_ADDR, REG_WDATA, REG_NARROW} <= {w, !w, a, d, n};
        @(posedge CORE_CLK);
        {REG_WR, REG_RD} <= 2'h0;
        @(negedge CORE_CLK);
        if (!w) chk_word(REG_RDATA, d);
        chk_bit(FAULT, f);
    endtask
    // one event pulse; the word feeds every event data port
    task automatic fire(logic [6:0] v, word_t d = 32'h0);
        @(posedge CORE_CLK);
        {PRIV_OP, EXC_ENTRY, EXC_RETURN, CALL, PC_LOAD, FLAGS_WE, BB_REQ} <= v;
        {EXC_NUM, CALL_RET_ADDR, PC_VALUE, FLAGS_IN, BB_ADDR} <= {d[8:0], d, d, d[4:0], d};
        @(posedge CORE_CLK);
        {PRIV_OP, EXC_ENTRY, EXC_RETURN, CALL, PC_LOAD, FLAGS_WE, BB_REQ} <= 7'h00;
        @(negedge CORE_CLK);
    endtask
    task automatic irq(irq_kind_e k, logic [8:0] p, logic e);
        @(posedge CORE_CLK);
        {IRQ_REQ, IRQ_PRIO} <= {1'b1, p};
        IRQ_KIND <= k;
        @(posedge CORE_CLK);
        IRQ_REQ <= 1'b0;
        @(negedge CORE_CLK);
        chk_bit(IRQ_VALID, 1'b1);
        chk_bit(IRQ_ADMIT, e);
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_after_reset;
        chk_word({29'h0, USER_LEVEL, HANDLER_MODE, THREAD_STACK_SEL}, 32'h0);
        for (int i = 20; i < 24; i++) acc(1'b0, idx_t'(i), 32'h0);
        acc(1'b0, IDX_EXECSTATE, 32'h0100_0000);
    endtask
    task automatic t_regs;
        acc(1'b1, 5'h00, 32'hFFFF_FFFF);
        acc(1'b1, IDX_HIGH_LAST, 32'h8000_0001);
        acc(1'b0, 5'h00, 32'hFFFF_FFFF);
        acc(1'b0, IDX_LOW_LAST, 32'h0, 1'b0, 1'b1);
        acc(1'b0, IDX_HIGH_LAST, 32'h0, 1'b1, 1'b1);
        acc(1'b0, IDX_HIGH_LAST, 32'h8000_0001);
        acc(1'b0, 5'h1F, 32'h0);
    endtask
    task automatic t_modes;
        acc(1'b1, IDX_MAIN_SP, 32'h1000_0007);
        acc(1'b0, IDX_MAIN_SP, 32'h1000_0004);
        acc(1'b1, IDX_THREAD_SP, 32'h2000_0003);
        chk_word(ACTIVE_SP, 32'h1000_0004);
        acc(1'b1, IDX_MODECTL, 32'h3);
        chk_bit(USER_LEVEL, 1'b1);
        chk_word(ACTIVE_SP, 32'h2000_0000);
        acc(1'b0, IDX_GMASK, 32'h0, 1'b1);
        fire(EV_PRIV);
        chk_bit(FAULT, 1'b1);
        fire(EV_IN, 32'h1FF);
        chk_word({HANDLER_MODE, USER_LEVEL, ACTIVE_SP[29:0]}, 32'h9000_0004);
        acc(1'b0, IDX_EXCNUM, 32'h1FF);
        acc(1'b0, IDX_MODECTL, 32'h1);
        fire(EV_PRIV);
        chk_bit(FAULT, 1'b0);
        fire(EV_OUT);
        chk_bit(THREAD_STACK_SEL, 1'b1);
        fire(EV_IN, 32'h003);
        acc(1'b1, IDX_MODECTL, 32'h0);
        fire(EV_OUT);
        chk_word({HANDLER_MODE, USER_LEVEL, THREAD_STACK_SEL}, 32'h0);
    endtask
    task automatic t_status;
        fire(EV_FLAGS, 32'h15);
        acc(1'b0, IDX_FLAGS, 32'hA800_0000);
        acc(1'b1, IDX_COMBINED, 32'h6100_0000);
        acc(1'b0, IDX_FLAGS, 32'h6000_0000);
        acc(1'b1, IDX_EXECSTATE, 32'h0700_FC00);
        acc(1'b0, IDX_EXECSTATE, 32'h0700_FC00);
        acc(1'b1, IDX_EXECSTATE, 32'h0, 1'b1);
        acc(1'b0, IDX_EXECSTATE, 32'h0700_FC00);
    endtask
    task automatic t_flow;
        fire(EV_CALL, 32'h0800_1235);
        acc(1'b0, IDX_LR, 32'h0800_1235);
        fire(EV_LOAD, 32'h0000_0101);
        chk_word(PROGRAM_COUNTER, 32'h0000_0100);
        acc(1'b1, IDX_PC, 32'h0000_0203);
        acc(1'b0, IDX_PC, 32'h0000_0202);
        fire(EV_BAND, 32'h2200_0084);
        chk_word({BB_VALID, BB_HIT, BB_BIT, BB_WORD_ADDR[24:0]}, 32'hC200_0004);
        fire(EV_BAND, 32'h21FF_FFFC);
        chk_bit(BB_HIT, 1'b0);
    endtask
    task automatic t_irq;
        irq(KIND_OTHER, 9'h1FF, 1'b1);
        acc(1'b1, IDX_THRESH, 32'hFFFF_FE04);
        acc(1'b0, IDX_THRESH, 32'h0000_0004);
        irq(KIND_OTHER, 9'h004, 1'b0);
        irq(KIND_OTHER, 9'h003, 1'b1);
        acc(1'b1, IDX_GMASK, 32'h1);
        irq(KIND_OTHER, 9'h001, 1'b0);
        irq(KIND_HARDFAULT, 9'h001, 1'b1);
        acc(1'b1, IDX_GMASK, 32'h0);
        acc(1'b1, IDX_FMASK, 32'h1);
        irq(KIND_HARDFAULT, 9'h001, 1'b0);
        irq(KIND_NMI, 9'h001, 1'b1);
    endtask
    // --------
    // run control
    // --------
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // budget is about thirty-five times the directed run
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        t_after_reset();
        t_regs();
        t_modes();
        t_status();
        t_flow();
        t_irq();
        report_and_stop();
    end
endmodule
`default_nettype wire
